/* File: inc/mgmt_consts.vh */
// Constants for the module management and status block.
`ifndef MGMT_CONSTS_VH
`define MGMT_CONSTS_VH

`define CLK_MHZ         100
`define T_INIT_MS       2000
`define T_RST_INIT_US   2
`define T_LOW_POWER_PIN_US     100
`define T_INT_ASSERT_MS 200
`define T_INT_CLEAR_US  500
`define T_MASK_MS       100
`define T_SELECT_US     100
`define T_PDOWN_MS      100
`define T_PDOWN_OFF_MS  300
`define INIT_CYC        (`T_INIT_MS * 1000 * `CLK_MHZ)
`define RST_CYC         (`T_RST_INIT_US * `CLK_MHZ)

`define DEV_ADDR        7'h50
`define ADDR_ID         8'h00
`define ADDR_STATUS     8'h02
`define ADDR_LOS_FLAG   8'h03
`define ADDR_TXF_FLAG   8'h04
`define ADDR_OTH_FLAG   8'h05
`define ADDR_CONTROL    8'h5d
`define ADDR_MASK_LO    8'h64
`define ADDR_MASK_HI    8'h6a
`define ADDR_PAGE_SEL   8'h7f
`define PAGE_USER       8'h02
`define NOT_READY_BIT   0
`define PDOWN_BIT       0
`define MASK_LOS_IDX    3'h0
`define MASK_TXF_IDX    3'h1
`define MASK_OTH_IDX    3'h2
`define RST_VAL_MASK    8'h00
`define RST_VAL_CTRL    8'h00
`define RST_VAL_PAGE    8'h00

`endif

/* File: rtl/user_mem.v */
// Small synchronous byte memory holding the user page.
`timescale 1ns/1ps
module user_mem #(
    parameter AW = 7,
    parameter DW = 8
) (
    // Clock.
    input  wire          clk_i,
    // Write side.
    input  wire          wr_en_i,
    input  wire [AW-1:0] wr_addr_i,
    input  wire [DW-1:0] wr_data_i,
    // Read side.
    input  wire [AW-1:0] rd_addr_i,
    output reg  [DW-1:0] rd_data_o
);
    reg [DW-1:0] mem_q [0:(1<<AW)-1];

    always @(posedge clk_i)
    begin
        if (wr_en_i)
        begin
            mem_q[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem_q[rd_addr_i];
    end
endmodule // user_mem

/* File: rtl/module_mgmt_status_timing.v */
// Module side management: init, reset filter, select, low power and interrupt.
`timescale 1ns/1ps
`include "mgmt_consts.vh"
module module_mgmt_status_timing #(
    parameter       INIT_CYCLES = `INIT_CYC,
    parameter       CNT_W       = 28,
    parameter [7:0] ID_CODE     = 8'h00 // Arbitrary identity value.
) (
    // Clock and reset.
    input  wire       CLK_I,
    input  wire       RST_B_I,
    // Two-wire management bus.
    input  wire       SCL_I,
    input  wire       SDA_I,
    output wire       SDA_O,
    output reg        SDA_OE_O,
    // Host control pins.
    input  wire       MODULE_SELECT_N_I,
    input  wire       MODULE_RST_IN_N_I,
    input  wire       LOW_POWER_PIN_I,
    // Flag conditions.
    input  wire [3:0] RX_LOS_I,
    input  wire [3:0] TX_FAULT_I,
    input  wire [7:0] OTHER_COND_I,
    // Status outputs.
    output reg        INTERRUPT_OUT_N_O,
    output reg        LOW_POWER_O,
    output reg        DATA_NOT_READY_O
);
    localparam [2:0] ST_IDLE  = 3'h0;
    localparam [2:0] ST_ADDR  = 3'h1;
    localparam [2:0] ST_AACK  = 3'h2;
    localparam [2:0] ST_WDATA = 3'h3;
    localparam [2:0] ST_WACK  = 3'h4;
    localparam [2:0] ST_RDATA = 3'h5;
    localparam [2:0] ST_RACK  = 3'h6;
    localparam integer     RST_LIM_I   = `RST_CYC;
    localparam integer     INIT_LAST_I = INIT_CYCLES - 1;
    localparam [8:0]       RST_LIM     = RST_LIM_I[8:0];
    localparam [CNT_W-1:0] INIT_LAST   = INIT_LAST_I[CNT_W-1:0];

    // Pin synchronisers.
    reg  [20:0]      sync1_q;
    reg  [20:0]      sync2_q;
    reg              scl_prev_q;
    reg              sda_prev_q;
    reg  [15:0]      cond_prev_q;
    // Reset filter and init.
    reg  [8:0]       rst_cnt_q;
    reg              mod_rst_q;
    reg  [CNT_W-1:0] init_cnt_q;
    reg              init_flag_q;
    // Flags, masks and control.
    reg  [3:0]       los_flag_q;
    reg  [3:0]       txf_flag_q;
    reg  [7:0]       oth_flag_q;
    reg  [7:0]       mask_q [0:6];
    reg  [7:0]       ctrl_q;
    reg  [7:0]       page_q;
    // Serial slave.
    reg  [2:0]       state_q;
    reg  [3:0]       bit_cnt_q;
    reg  [7:0]       shift_q;
    reg              rw_q;
    reg              first_q;
    reg  [7:0]       addr_q;
    reg  [7:0]       rd_byte;
    wire [7:0]       mem_rdata;
    integer          i;

    wire        scl       = sync2_q[0];
    wire        sda       = sync2_q[1];
    wire        sel_n     = sync2_q[2];
    wire        rst_pin_n = sync2_q[3];
    wire        lp_pin    = sync2_q[4];
    wire [15:0] cond      = sync2_q[20:5];
    wire [15:0] cond_rise = cond & ~cond_prev_q;
    wire        scl_rise  = scl & ~scl_prev_q;
    wire        scl_fall  = ~scl & scl_prev_q;
    wire        start_c   = scl & scl_prev_q & ~sda & sda_prev_q;
    wire        stop_c    = scl & scl_prev_q & sda & ~sda_prev_q;
    wire [7:0]  mask_off  = addr_q - `ADDR_MASK_LO;
    wire        in_mask   = (addr_q >= `ADDR_MASK_LO) && (addr_q <= `ADDR_MASK_HI);
    // Bus answers only while selected and out of module reset.
    wire        bus_on    = ~sel_n & ~mod_rst_q;
    wire        rd_load   = bus_on & scl_fall
                            & (((state_q == ST_AACK) & rw_q) | (state_q == ST_RACK));
    wire        wr_commit = bus_on & scl_fall & (state_q == ST_WDATA)
                            & (bit_cnt_q == 4'h8) & ~first_q;
    wire [7:0]  los_clr   = (rd_load && addr_q == `ADDR_LOS_FLAG) ? {4'h0, los_flag_q} : 8'h00;
    wire [7:0]  txf_clr   = (rd_load && addr_q == `ADDR_TXF_FLAG) ? {4'h0, txf_flag_q} : 8'h00;
    wire [7:0]  oth_clr   = (rd_load && addr_q == `ADDR_OTH_FLAG) ? oth_flag_q : 8'h00;
    wire        stat_clr  = rd_load && (addr_q == `ADDR_STATUS);
    assign SDA_O = 1'b0;

    // Pins enter through two flip-flops.
    always @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            sync1_q     <= 21'h00000f;
            sync2_q     <= 21'h00000f;
            scl_prev_q  <= 1'b1;
            sda_prev_q  <= 1'b1;
            cond_prev_q <= 16'h0000;
        end
        else
        begin
            sync1_q     <= {OTHER_COND_I, TX_FAULT_I, RX_LOS_I, LOW_POWER_PIN_I,
                            MODULE_RST_IN_N_I, MODULE_SELECT_N_I, SDA_I, SCL_I};
            sync2_q     <= sync1_q;
            scl_prev_q  <= scl;
            sda_prev_q  <= sda;
            cond_prev_q <= cond;
        end
    end

    // Reset filter, init timer and flag registers.
    always @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            rst_cnt_q        <= 9'h000;
            mod_rst_q        <= 1'b0;
            init_cnt_q       <= {CNT_W{1'b0}};
            DATA_NOT_READY_O <= 1'b1;
            init_flag_q      <= 1'b0;
            los_flag_q       <= 4'h0;
            txf_flag_q       <= 4'h0;
            oth_flag_q       <= 8'h00;
        end
        else
        begin
            if (rst_pin_n)
            begin
                rst_cnt_q <= 9'h000;
                mod_rst_q <= 1'b0;
            end
            else if (rst_cnt_q > RST_LIM)
                mod_rst_q <= 1'b1;
            else
                rst_cnt_q <= rst_cnt_q + 9'h001;
            if (mod_rst_q)
            begin
                init_cnt_q       <= {CNT_W{1'b0}};
                DATA_NOT_READY_O <= 1'b1;
                init_flag_q      <= 1'b0;
                los_flag_q       <= 4'h0;
                txf_flag_q       <= 4'h0;
                oth_flag_q       <= 8'h00;
            end
            else
            begin
                if (DATA_NOT_READY_O)
                    init_cnt_q <= init_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
                if (DATA_NOT_READY_O && init_cnt_q == INIT_LAST)
                begin
                    DATA_NOT_READY_O <= 1'b0;
                    init_flag_q      <= 1'b1;
                end
                else if (stat_clr)
                    init_flag_q <= 1'b0;
                // Clear on read; a new event wins.
                los_flag_q <= (los_flag_q & ~los_clr[3:0]) | cond_rise[3:0];
                txf_flag_q <= (txf_flag_q & ~txf_clr[3:0]) | cond_rise[7:4];
                oth_flag_q <= (oth_flag_q & ~oth_clr) | cond_rise[15:8];
            end
        end
    end

    // Outputs derived from flags, masks and power control.
    always @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            INTERRUPT_OUT_N_O <= 1'b1;
            LOW_POWER_O       <= 1'b0;
        end
        else
        begin
            INTERRUPT_OUT_N_O <= ~(init_flag_q
                                   | (|(los_flag_q & ~mask_q[`MASK_LOS_IDX][3:0]))
                                   | (|(txf_flag_q & ~mask_q[`MASK_TXF_IDX][3:0]))
                                   | (|(oth_flag_q & ~mask_q[`MASK_OTH_IDX])));
            LOW_POWER_O <= lp_pin | ctrl_q[`PDOWN_BIT];
        end
    end

    // Read data selection by byte address.
    always @*
    begin
        rd_byte = 8'h00;
        if (addr_q[7])
        begin
            if (page_q == `PAGE_USER)
                rd_byte = mem_rdata;
        end
        else if (in_mask)
            rd_byte = mask_q[mask_off[2:0]];
        else
            case (addr_q)
                `ADDR_ID:       rd_byte = ID_CODE;
                `ADDR_STATUS:   rd_byte = {7'h00, DATA_NOT_READY_O};
                `ADDR_LOS_FLAG: rd_byte = {4'h0, los_flag_q};
                `ADDR_TXF_FLAG: rd_byte = {4'h0, txf_flag_q};
                `ADDR_OTH_FLAG: rd_byte = oth_flag_q;
                `ADDR_CONTROL:  rd_byte = ctrl_q;
                `ADDR_PAGE_SEL: rd_byte = page_q;
                default:        rd_byte = 8'h00;
            endcase
    end

    // Control registers written over the serial bus.
    always @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            ctrl_q <= `RST_VAL_CTRL;
            page_q <= `RST_VAL_PAGE;
            for (i = 0; i < 7; i = i + 1)
                mask_q[i] <= `RST_VAL_MASK;
        end
        else if (mod_rst_q)
        begin
            ctrl_q <= `RST_VAL_CTRL;
            page_q <= `RST_VAL_PAGE;
            for (i = 0; i < 7; i = i + 1)
                mask_q[i] <= `RST_VAL_MASK;
        end
        else if (wr_commit)
        begin
            if (in_mask)
                mask_q[mask_off[2:0]] <= shift_q;
            if (addr_q == `ADDR_CONTROL)
                ctrl_q <= shift_q;
            if (addr_q == `ADDR_PAGE_SEL)
                page_q <= shift_q;
        end
    end

    // Two-wire serial slave.
    always @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            state_q   <= ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q   <= 8'h00;
            rw_q      <= 1'b0;
            first_q   <= 1'b0;
            addr_q    <= 8'h00;
            SDA_OE_O  <= 1'b0;
        end
        else if (!bus_on || stop_c)
        begin
            state_q  <= ST_IDLE;
            SDA_OE_O <= 1'b0;
        end
        else if (start_c)
        begin
            state_q   <= ST_ADDR;
            bit_cnt_q <= 4'h0;
            SDA_OE_O  <= 1'b0;
        end
        else
        begin
            case (state_q)
                ST_ADDR, ST_WDATA:
                begin
                    if (scl_rise && bit_cnt_q != 4'h8)
                    begin
                        shift_q   <= {shift_q[6:0], sda};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end
                    else if (scl_fall && bit_cnt_q == 4'h8)
                    begin
                        if (state_q == ST_WDATA)
                        begin
                            SDA_OE_O <= 1'b1;
                            state_q  <= ST_WACK;
                            first_q  <= 1'b0;
                            addr_q   <= first_q ? shift_q : addr_q + 8'h01;
                        end
                        else if (shift_q[7:1] == `DEV_ADDR)
                        begin
                            SDA_OE_O <= 1'b1;
                            rw_q     <= shift_q[0];
                            state_q  <= ST_AACK;
                        end
                        else
                            state_q <= ST_IDLE;
                    end
                end
                ST_AACK, ST_RACK:
                begin
                    if (rd_load)
                    begin
                        shift_q   <= rd_byte;
                        SDA_OE_O  <= ~rd_byte[7];
                        bit_cnt_q <= 4'h0;
                        addr_q    <= addr_q + 8'h01;
                        state_q   <= ST_RDATA;
                    end
                    else if (scl_fall)
                    begin
                        SDA_OE_O  <= 1'b0;
                        bit_cnt_q <= 4'h0;
                        first_q   <= 1'b1;
                        state_q   <= ST_WDATA;
                    end
                    else if (scl_rise && state_q == ST_RACK && sda)
                        state_q <= ST_IDLE;
                end
                ST_WACK:
                begin
                    if (scl_fall)
                    begin
                        SDA_OE_O  <= 1'b0;
                        bit_cnt_q <= 4'h0;
                        state_q   <= ST_WDATA;
                    end
                end
                ST_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (bit_cnt_q == 4'h7)
                        begin
                            SDA_OE_O <= 1'b0;
                            state_q  <= ST_RACK;
                        end
                        else
                        begin
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                            shift_q   <= {shift_q[6:0], 1'b0};
                            SDA_OE_O  <= ~shift_q[6];
                        end
                    end
                end
                default:
                    SDA_OE_O <= 1'b0;
            endcase
        end
    end

    user_mem #(.AW (7), .DW (8)) user_mem_inst (
        .clk_i     (CLK_I),
        .wr_en_i   (wr_commit & addr_q[7] & (page_q == `PAGE_USER)),
        .wr_addr_i (addr_q[6:0]),
        .wr_data_i (shift_q),
        .rd_addr_i (addr_q[6:0]),
        .rd_data_o (mem_rdata)
    );
endmodule // module_mgmt_status_timing

/* File: testbench/mgmt_status_chk.sv */
// Concurrent checks on the ports of the module management block.
`timescale 1ns/1ps
module mgmt_status_chk #(
    parameter INIT_CYCLES = 1000
) (
    input wire logic       CLK_I,
    input wire logic       RST_B_I,
    input wire logic       SCL_I,
    input wire logic       SDA_OE_O,
    input wire logic       MODULE_SELECT_N_I,
    input wire logic       MODULE_RST_IN_N_I,
    input wire logic       LOW_POWER_PIN_I,
    input wire logic [3:0] RX_LOS_I,
    input wire logic [3:0] TX_FAULT_I,
    input wire logic [7:0] OTHER_COND_I,
    input wire logic       INTERRUPT_OUT_N_O,
    input wire logic       LOW_POWER_O,
    input wire logic       DATA_NOT_READY_O
);
    logic [31:0] run_q;
    logic [15:0] low_q;
    logic [7:0]  quiet_q;
    logic [17:0] prev_q;
    logic [17:0] cur;
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    assign cur = {SCL_I, DATA_NOT_READY_O, RX_LOS_I, TX_FAULT_I, OTHER_COND_I};
    // Time since reset pin release, its low run, and time since any change on the bus clock, not-ready flag or condition inputs.
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            run_q   <= 32'h0;
            low_q   <= 16'h0;
            quiet_q <= 8'h0;
            prev_q  <= 18'h0;
        end
        else
        begin
            run_q   <= !MODULE_RST_IN_N_I ? 32'h0 : run_q + {31'h0, run_q != 32'hffffffff};
            low_q   <= MODULE_RST_IN_N_I ? 16'h0 : low_q + {15'h0, low_q != 16'hffff};
            quiet_q <= (cur != prev_q) ? 8'h0 : quiet_q + {7'h0, quiet_q != 8'hff};
            prev_q  <= cur;
        end
    end
    a_init_deadline: assert property (run_q > INIT_CYCLES + 8 |-> !DATA_NOT_READY_O)
        else $error("Not-ready flag still high after the init time.");
    a_init_int_follows: assert property ($fell(DATA_NOT_READY_O) |-> ##[0:2] !INTERRUPT_OUT_N_O)
        else $error("Interrupt not asserted after init completed.");
    a_low_power_pin: assert property (LOW_POWER_PIN_I [*5] |-> LOW_POWER_O)
        else $error("Low power not entered after the pin rose.");
    a_deselect_quiet: assert property (MODULE_SELECT_N_I [*6] |-> !SDA_OE_O)
        else $error("Data line driven while deselected.");
    a_long_reset_holds: assert property (low_q > 16'h00d2 |-> DATA_NOT_READY_O && !SDA_OE_O)
        else $error("Long reset pulse not taken as a reset.");
    a_short_pulse_ignored: assert property (
        !MODULE_RST_IN_N_I && low_q < 16'h00be && !DATA_NOT_READY_O |=> !DATA_NOT_READY_O)
        else $error("Short reset pulse taken as a reset.");
    a_int_has_cause: assert property ($fell(INTERRUPT_OUT_N_O) |-> quiet_q < 8'h10)
        else $error("Interrupt asserted with no recent cause.");
    a_sda_moves_low: assert property (
        $changed(SDA_OE_O) && !MODULE_SELECT_N_I && MODULE_RST_IN_N_I |-> !SCL_I)
        else $error("Data line changed while bus clock high.");
endmodule // mgmt_status_chk

bind module_mgmt_status_timing mgmt_status_chk #(.INIT_CYCLES(INIT_CYCLES)) mgmt_status_chk_inst (
    .CLK_I(CLK_I), .RST_B_I(RST_B_I), .SCL_I(SCL_I), .SDA_OE_O(SDA_OE_O),
    .MODULE_SELECT_N_I(MODULE_SELECT_N_I), .MODULE_RST_IN_N_I(MODULE_RST_IN_N_I),
    .LOW_POWER_PIN_I(LOW_POWER_PIN_I), .RX_LOS_I(RX_LOS_I), .TX_FAULT_I(TX_FAULT_I),
    .OTHER_COND_I(OTHER_COND_I), .INTERRUPT_OUT_N_O(INTERRUPT_OUT_N_O),
    .LOW_POWER_O(LOW_POWER_O), .DATA_NOT_READY_O(DATA_NOT_READY_O));

/* File: testbench/host_bus_model.sv */
// Host side model: two-wire bus master on an open-drain, pulled-up data line.
`timescale 1ns/1ps
module host_bus_model (
    input  wire logic clk_i,
    input  wire logic dev_oe_i,
    output logic      scl_o,
    output wire logic sda_o
);
    logic pull_low = 1'b0;
    initial scl_o = 1'b1;
    // The pull-up wins unless either party pulls the line low.
    assign sda_o = ~(pull_low | dev_oe_i);
    task automatic half();
        repeat (8) @(posedge clk_i);
    endtask
    task automatic put_bit(input logic b, output logic r);
        pull_low <= ~b;
        half();
        scl_o <= 1'b1;
        half();
        r = sda_o;
        scl_o <= 1'b0;
    endtask
    task automatic start();
        pull_low <= 1'b0;
        half();
        scl_o <= 1'b1;
        half();
        pull_low <= 1'b1;
        half();
        scl_o <= 1'b0;
    endtask
    task automatic stop();
        pull_low <= 1'b1;
        half();
        scl_o <= 1'b1;
        half();
        pull_low <= 1'b0;
        half();
    endtask
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            put_bit(d[i], r);
        put_bit(1'b1, r);
        ack = ~r;
    endtask
    task automatic recv(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            put_bit(1'b1, d[i]);
        put_bit(last, r);
    endtask
endmodule // host_bus_model

/* File: testbench/module_mgmt_status_timing_tb.sv */
// Self-checking bench for the module management block.
`timescale 1ns/1ps
`include "mgmt_consts.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin err_count++; $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module module_mgmt_status_timing_tb;
    localparam [7:0] ID = 8'h5a; // Arbitrary identity value.
    logic       clk    = 1'b0;
    logic       rst_b  = 1'b0;
    logic       sel_n  = 1'b0;
    logic       mrst_n = 1'b1;
    logic       lp_pin = 1'b0;
    logic [3:0] los    = 4'h0;
    logic [3:0] txf    = 4'h0;
    logic [7:0] oth    = 8'h00;
    wire        scl, sda, oe, int_n, lp, dnr, sda_out;
    int         err_count = 0;
    int         compares  = 0;
    initial
    begin
        forever #5 clk = ~clk;
    end
    module_mgmt_status_timing #(.INIT_CYCLES(1000), .ID_CODE(ID)) module_mgmt_status_timing_inst (
        .CLK_I(clk), .RST_B_I(rst_b), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_out), .SDA_OE_O(oe),
        .MODULE_SELECT_N_I(sel_n), .MODULE_RST_IN_N_I(mrst_n), .LOW_POWER_PIN_I(lp_pin),
        .RX_LOS_I(los), .TX_FAULT_I(txf), .OTHER_COND_I(oth), .INTERRUPT_OUT_N_O(int_n),
        .LOW_POWER_O(lp), .DATA_NOT_READY_O(dnr));
    host_bus_model host_bus_model_inst (.clk_i(clk), .dev_oe_i(oe), .scl_o(scl), .sda_o(sda));
    task automatic tally_and_finish();
        $display("Counts: %0d compares, %0d mismatches", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] off, input logic [7:0] d);
        logic a0, a1, a2;
        host_bus_model_inst.start();
        host_bus_model_inst.send({`DEV_ADDR, 1'b0}, a0);
        host_bus_model_inst.send(off, a1);
        host_bus_model_inst.send(d, a2);
        host_bus_model_inst.stop();
        `CHK({a0, a1, a2}, 3'b111)
    endtask
    task automatic rd(input logic [7:0] off, input logic [7:0] e, input logic ack_e);
        logic       a0, a1, a2;
        logic [7:0] d;
        host_bus_model_inst.start();
        host_bus_model_inst.send({`DEV_ADDR, 1'b0}, a0);
        host_bus_model_inst.send(off, a1);
        host_bus_model_inst.start();
        host_bus_model_inst.send({`DEV_ADDR, 1'b1}, a2);
        if (a2)
            host_bus_model_inst.recv(1'b1, d);
        host_bus_model_inst.stop();
        `CHK({a0, a1, a2}, {3{ack_e}})
        if (ack_e)
            `CHK(d, e)
    endtask
    // Waits for interrupt (0), not-ready (1) or low power (2) to reach a level.
    task automatic wait_for(input int which, input logic lvl);
        int n;
        n = 0;
        compares++;
        while ((which == 0 ? int_n : which == 1 ? dnr : lp) !== lvl)
        begin
            @(posedge clk);
            n++;
            if (n > 1200)
            begin
                err_count++;
                $display("BAD %0t wait ran out", $time);
                tally_and_finish();
            end
        end
    endtask
    initial
    begin
        repeat (90000) @(posedge clk);
        err_count++;
        $display("BAD %0t run too long", $time);
        tally_and_finish();
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        wait_for(1, 1'b0);
        wait_for(0, 1'b0);
        rd(`ADDR_ID, ID, 1'b1);
        `CHK(sda_out, 1'b0)
        rd(`ADDR_STATUS, 8'h00, 1'b1);
        wait_for(0, 1'b1);
        $display("Test init done");
        for (int k = 0; k < 3; k++)
        begin
            los <= (k == 0) ? 4'h4 : 4'h0;
            txf <= (k == 1) ? 4'h2 : 4'h0;
            oth <= (k == 2) ? 8'h81 : 8'h00;
            wait_for(0, 1'b0);
            rd(`ADDR_LOS_FLAG + 8'(k), k == 0 ? 8'h04 : k == 1 ? 8'h02 : 8'h81, 1'b1);
            wait_for(0, 1'b1);
        end
        oth <= 8'h00;
        los <= 4'h2;
        txf <= 4'h1;
        wait_for(0, 1'b0);
        rd(`ADDR_LOS_FLAG, 8'h02, 1'b1);
        repeat (20) @(posedge clk);
        `CHK(int_n, 1'b0)
        rd(`ADDR_TXF_FLAG, 8'h01, 1'b1);
        wait_for(0, 1'b1);
        $display("Test flags done");
        wr(`ADDR_MASK_LO, 8'h01);
        rd(`ADDR_MASK_LO, 8'h01, 1'b1);
        los <= 4'h1;
        repeat (50) @(posedge clk);
        `CHK(int_n, 1'b1)
        wr(`ADDR_MASK_LO, 8'h00);
        wait_for(0, 1'b0);
        rd(`ADDR_LOS_FLAG, 8'h01, 1'b1);
        wait_for(0, 1'b1);
        $display("Test masks done");
        lp_pin <= 1'b1;
        wait_for(2, 1'b1);
        lp_pin <= 1'b0;
        wait_for(2, 1'b0);
        wr(`ADDR_CONTROL, 8'h01);
        wait_for(2, 1'b1);
        wr(`ADDR_CONTROL, 8'h00);
        wait_for(2, 1'b0);
        $display("Test low power done");
        sel_n <= 1'b1;
        repeat (10) @(posedge clk);
        rd(`ADDR_ID, ID, 1'b0);
        sel_n <= 1'b0;
        repeat (10) @(posedge clk);
        rd(`ADDR_ID, ID, 1'b1);
        wr(`ADDR_PAGE_SEL, `PAGE_USER);
        wr(8'hc8, 8'h3c);
        rd(8'hc8, 8'h3c, 1'b1);
        wr(`ADDR_PAGE_SEL, 8'h00);
        rd(8'hc8, 8'h00, 1'b1);
        $display("Test select and page done");
        wr(`ADDR_MASK_HI, 8'h3c);
        rd(`ADDR_MASK_HI, 8'h3c, 1'b1);
        mrst_n <= 1'b0;
        repeat (150) @(posedge clk);
        mrst_n <= 1'b1;
        repeat (10) @(posedge clk);
        `CHK(dnr, 1'b0)
        rd(`ADDR_MASK_HI, 8'h3c, 1'b1);
        mrst_n <= 1'b0;
        repeat (250) @(posedge clk);
        `CHK(dnr, 1'b1)
        mrst_n <= 1'b1;
        wait_for(1, 1'b0);
        rd(`ADDR_MASK_HI, 8'h00, 1'b1);
        $display("Test module reset done");
        tally_and_finish();
    end
endmodule // module_mgmt_status_timing_tb
